// File: src/rpt_timer_top.sv
`timescale 1ns/1ps
// Functional notes
// - The pulse width override register is cleared at reset, while disabled and on a protocol write.
// - An override of zero leaves the pulse width to the selected protocol.
// - A nonzero override N makes each pulse last N steps of 73.7 ns.
// - Protocol widths are 2.36 us, 1.4 us, 737 ns and 442 ns for 106, 212, 424 and 848 kbps.
// - The silence window register is set to 0x0E at reset, while disabled and on a protocol write.
// - Each new protocol selection presets the window to about 529 us.
// - The window starts at the end of transmit and stops when a tag response begins.
// - If the window runs out with no response, the flag and interrupt are raised.
// - The window lasts the register value times 37.76 us.
module rpt_timer_top
  import rpt_pkg::*;
#(
  parameter int unsigned SILENCE_STEP_CYC = SILENCE_STEP_CYC_DEF
)(
  input  wire logic   REF_CLK_I,       // reference clock, 200 MHz
  input  wire logic   SRST_I,          // sync reset, high
  input  wire logic   EN_I,            // device enable pin, low disables
  input  rpt_reg_req_t REG_REQ_I,      // register read or write request
  input  wire logic   PROTO_WR_I,      // protocol selection written
  input  rpt_rate_t   PROTO_RATE_I,    // selected type A rate
  input  wire logic   TX_PULSE_REQ_I,  // start a modulation pulse
  input  wire logic   TX_EOF_DONE_I,   // transmit end of frame finished
  input  wire logic   RX_START_I,      // tag response began
  input  wire logic   FLAG_CLR_I,      // clear the no-response flag
  output logic [7:0]  REG_RDATA_O,     // read data
  output logic        TX_MOD_O,        // modulation pulse level
  output logic        IRQ_O,           // interrupt request, high
  output logic        NO_RESP_FLAG_O,  // no-response flag
  output logic        TIMER_BUSY_O     // window running
);

  localparam int PSW = $clog2(SILENCE_STEP_CYC + 1);
  localparam logic [PSW-1:0] PS_LAST = PSW'(SILENCE_STEP_CYC - 1);

  logic           en_s1_reg;
  logic           en_s2_reg;
  logic           en_s3_reg;
  logic           en_reg;
  logic           preset;
  logic [7:0]     pw_reg;
  logic [7:0]     sw_reg;
  logic [7:0]     rdata_reg;
  rpt_tstate_t    state_reg;
  logic [PSW-1:0] ps_reg;
  logic [7:0]     units_reg;
  logic           expire;
  logic           flag_reg;
  logic [20:0]    elapsed_reg;
  logic [7:0]     load_reg;

  ////////////////////////////////////////////////////////////////////////////
  // enable pin: three stages, level taken once stages two and three agree
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
      en_s3_reg <= 1'b0;
    end else begin
      en_s1_reg <= EN_I;
      en_s2_reg <= en_s1_reg;
      en_s3_reg <= en_s2_reg;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      en_reg <= 1'b0;
    end else if (en_s2_reg == en_s3_reg) begin
      en_reg <= en_s3_reg;
    end
  end

  assign preset = !en_reg || PROTO_WR_I;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || preset) begin
      pw_reg <= PW_RESET;
    end else if (REG_REQ_I.wr && REG_REQ_I.addr == PW_OFFSET) begin
      pw_reg <= REG_REQ_I.wdata;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || preset) begin
      sw_reg <= SW_RESET;
    end else if (REG_REQ_I.wr && REG_REQ_I.addr == SW_OFFSET) begin
      sw_reg <= REG_REQ_I.wdata;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      rdata_reg <= 8'h00;
    end else if (REG_REQ_I.rd) begin
      unique case (REG_REQ_I.addr)
        PW_OFFSET: rdata_reg <= pw_reg;
        SW_OFFSET: rdata_reg <= sw_reg;
        default:   rdata_reg <= 8'h00;
      endcase
    end
  end

  assign REG_RDATA_O = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // modulation pulse
  rpt_pulse_gen u_pulse (
    .clk_i   (REF_CLK_I),
    .srst_i  (SRST_I),
    .clr_i   (!en_reg),
    .start_i (TX_PULSE_REQ_I),
    .ovr_i   (pw_reg),
    .rate_i  (PROTO_RATE_I),
    .pulse_o (TX_MOD_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // no-response window
  assign expire = (state_reg == T_RUN) && (ps_reg == PS_LAST) && (units_reg == 8'h01)
                  && !RX_START_I && !TX_EOF_DONE_I;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || !en_reg) begin
      state_reg <= T_IDLE;
      ps_reg    <= '0;
      units_reg <= 8'h00;
    end else if (TX_EOF_DONE_I) begin
      // a zero window value leaves the timer off
      state_reg <= (sw_reg != 8'h00) ? T_RUN : T_IDLE;
      ps_reg    <= '0;
      units_reg <= sw_reg;
    end else if (state_reg == T_RUN) begin
      if (RX_START_I || expire) begin
        state_reg <= T_IDLE;
      end else if (ps_reg == PS_LAST) begin
        ps_reg    <= '0;
        units_reg <= units_reg - 8'h01;
      end else begin
        ps_reg <= ps_reg + PSW'(1);
      end
    end
  end

  // set wins over clear
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      flag_reg <= 1'b0;
    end else if (expire) begin
      flag_reg <= 1'b1;
    end else if (FLAG_CLR_I) begin
      flag_reg <= 1'b0;
    end
  end

  assign IRQ_O          = flag_reg;
  assign NO_RESP_FLAG_O = flag_reg;
  assign TIMER_BUSY_O   = (state_reg == T_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I || state_reg != T_RUN || TX_EOF_DONE_I) begin
      elapsed_reg <= 21'h000000;
    end else begin
      elapsed_reg <= elapsed_reg + 21'h000001;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      load_reg <= 8'h00;
    end else if (TX_EOF_DONE_I) begin
      load_reg <= sw_reg;
    end
  end

  property p_pw_preset;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    preset |=> (pw_reg == PW_RESET);
  endproperty
  a_pw_preset: assert property (p_pw_preset) else $error("override not cleared on preset");

  property p_sw_preset;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (PROTO_WR_I && en_reg) |=> (sw_reg == SW_RESET) && (pw_reg == PW_RESET);
  endproperty
  a_sw_preset: assert property (p_sw_preset) else $error("window not preset on protocol write");

  property p_proto_window;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (PROTO_WR_I && en_reg) ##1 (TX_EOF_DONE_I && !PROTO_WR_I && !REG_REQ_I.wr && en_reg) |=> (units_reg == SW_RESET);
  endproperty
  a_proto_window: assert property (p_proto_window) else $error("window not 0x0E after protocol write");

  property p_start;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (TX_EOF_DONE_I && en_reg && sw_reg != 8'h00 && en_s2_reg == en_s3_reg && en_s3_reg) |=> TIMER_BUSY_O;
  endproperty
  a_start: assert property (p_start) else $error("window did not start at end of transmit");

  property p_stop;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (RX_START_I && TIMER_BUSY_O && !TX_EOF_DONE_I) |=> !TIMER_BUSY_O && (flag_reg == $past(flag_reg) || !flag_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("response did not stop the window");

  property p_expire_flag;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    expire |=> flag_reg && IRQ_O && !TIMER_BUSY_O;
  endproperty
  a_expire_flag: assert property (p_expire_flag) else $error("expiry did not raise flag");

  property p_set_wins;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (expire && FLAG_CLR_I) |=> flag_reg;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new expiry");

  property p_window_len;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    expire |-> (elapsed_reg == 21'(load_reg * SILENCE_STEP_CYC - 1));
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");

  property p_restart;
    @(posedge REF_CLK_I) disable iff (SRST_I)
    (TX_EOF_DONE_I && en_reg && TIMER_BUSY_O) |=> (units_reg == $past(sw_reg)) && (ps_reg == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("window not restarted from register");

endmodule : rpt_timer_top

// File: src/rpt_pkg.sv
package rpt_pkg;

  // register map
  localparam logic [7:0] PW_OFFSET      = 8'h06;
  localparam logic [7:0] SW_OFFSET      = 8'h07;
  localparam logic [7:0] PW_RESET       = 8'h00;
  localparam logic [7:0] SW_RESET       = 8'h0E;

  // clock and timing
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned PULSE_STEP_PS   = 73700;
  localparam int unsigned PULSE_106_PS    = 2360000;
  localparam int unsigned PULSE_212_PS    = 1400000;
  localparam int unsigned PULSE_424_PS    = 737000;
  localparam int unsigned PULSE_848_PS    = 442000;
  localparam int unsigned SILENCE_STEP_NS = 37760;

  // pulse steps round up to whole cycles
  localparam logic [11:0] PULSE_STEP_CYC = 12'((PULSE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] PULSE_106_CYC  = 12'((PULSE_106_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] PULSE_212_CYC  = 12'((PULSE_212_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] PULSE_424_CYC  = 12'((PULSE_424_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [11:0] PULSE_848_CYC  = 12'((PULSE_848_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned SILENCE_STEP_CYC_DEF = (SILENCE_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    RATE_106,
    RATE_212,
    RATE_424,
    RATE_848
  } rpt_rate_t;

  typedef enum logic {
    T_IDLE,
    T_RUN
  } rpt_tstate_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpt_reg_req_t;

endpackage : rpt_pkg

// File: src/rpt_pulse_gen.sv
`timescale 1ns/1ps
module rpt_pulse_gen
  import rpt_pkg::*;
(
  input  wire logic       clk_i,    // reference clock
  input  wire logic       srst_i,   // sync reset, high
  input  wire logic       clr_i,    // abort pulse, high
  input  wire logic       start_i,  // start one modulation pulse
  input  wire logic [7:0] ovr_i,    // pulse width override value
  input  rpt_rate_t       rate_i,   // selected type A rate
  output logic            pulse_o   // modulation pulse level
);

  logic [11:0] len_next;
  logic [11:0] len_reg;
  logic [11:0] cnt_reg;
  logic        pulse_reg;
  logic [11:0] hi_cnt_reg;

  always_comb begin
    if (ovr_i != 8'h00) begin
      len_next = 12'(ovr_i * PULSE_STEP_CYC);
    end else begin
      unique case (rate_i)
        RATE_106: len_next = PULSE_106_CYC;
        RATE_212: len_next = PULSE_212_CYC;
        RATE_424: len_next = PULSE_424_CYC;
        RATE_848: len_next = PULSE_848_CYC;
      endcase
    end
  end

  // a start while a pulse is running is ignored
  always_ff @(posedge clk_i) begin
    if (srst_i || clr_i) begin
      pulse_reg <= 1'b0;
      cnt_reg   <= 12'h000;
      len_reg   <= 12'h000;
    end else if (start_i && !pulse_reg) begin
      pulse_reg <= 1'b1;
      cnt_reg   <= len_next - 12'h001;
      len_reg   <= len_next;
    end else if (pulse_reg) begin
      if (cnt_reg == 12'h000) begin
        pulse_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 12'h001;
      end
    end
  end

  assign pulse_o = pulse_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i || !pulse_reg) begin
      hi_cnt_reg <= 12'h000;
    end else begin
      hi_cnt_reg <= hi_cnt_reg + 12'h001;
    end
  end

  property p_pulse_len;
    @(posedge clk_i) disable iff (srst_i)
    ($fell(pulse_reg) && !$past(clr_i)) |-> (hi_cnt_reg == len_reg);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse width differs from loaded length");

  property p_ovr_len;
    @(posedge clk_i) disable iff (srst_i)
    (start_i && !pulse_reg && !clr_i && ovr_i != 8'h00) |=> (len_reg == 12'($past(ovr_i) * PULSE_STEP_CYC));
  endproperty
  a_ovr_len: assert property (p_ovr_len) else $error("override pulse length wrong");

  property p_zero_proto;
    @(posedge clk_i) disable iff (srst_i)
    (start_i && !pulse_reg && !clr_i && ovr_i == 8'h00 && rate_i == RATE_106) |=> (len_reg == PULSE_106_CYC);
  endproperty
  a_zero_proto: assert property (p_zero_proto) else $error("zero override did not use protocol width");

  property p_proto_848;
    @(posedge clk_i) disable iff (srst_i)
    (start_i && !pulse_reg && !clr_i && ovr_i == 8'h00 && rate_i == RATE_848) |=> (len_reg == PULSE_848_CYC);
  endproperty
  a_proto_848: assert property (p_proto_848) else $error("848 kbps pulse width wrong");

endmodule : rpt_pulse_gen

// File: dv/rpt_tag_model.sv
`timescale 1ns/1ps
module rpt_tag_model (
  input  wire logic       clk_i,   // clock
  input  wire logic       srst_i,  // sync reset, high
  input  wire logic       eof_i,   // transmit finished
  input  wire logic       resp_i,  // answer this slot
  input  wire logic [3:0] dly_i,   // reply delay, cycles
  output logic            rx_o     // reply start pulse
);
  logic [4:0] cnt_reg;
  // a tag answers only when told to, some cycles after the slot opens
  always_ff @(posedge clk_i) begin
    rx_o <= 1'b0;
    if (srst_i) begin
      cnt_reg <= 5'h00;
    end else if (eof_i && resp_i) begin
      cnt_reg <= {1'b0, dly_i};
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
      rx_o    <= (cnt_reg == 5'h01);
    end
  end
endmodule : rpt_tag_model

// File: dv/tb_rpt_timer_top.sv
`timescale 1ns/1ps
module tb_rpt_timer_top;
  import rpt_pkg::*;
  localparam int unsigned SCY = 4;
  logic         clk  = 1'b0;
  logic         srst = 1'b1;
  logic         en   = 1'b1;
  logic         pwr  = 1'b0;
  logic         resp = 1'b0;
  logic         rx;
  logic [2:0]   stb  = 3'h0;
  rpt_reg_req_t req  = '0;
  rpt_rate_t    rate = RATE_106;
  logic [7:0]   rdata;
  logic         tx_mod;
  logic         irq;
  logic         flag;
  logic         busy;
  int           n_fail = 0;
  int           tests_run = 0;
  int           n;

  always #2.5 clk = ~clk;

  rpt_timer_top #(.SILENCE_STEP_CYC(SCY)) i_dut (
    .REF_CLK_I(clk), .SRST_I(srst), .EN_I(en), .REG_REQ_I(req),
    .PROTO_WR_I(pwr), .PROTO_RATE_I(rate), .TX_PULSE_REQ_I(stb[0]),
    .TX_EOF_DONE_I(stb[1]), .RX_START_I(rx), .FLAG_CLR_I(stb[2]),
    .REG_RDATA_O(rdata), .TX_MOD_O(tx_mod), .IRQ_O(irq),
    .NO_RESP_FLAG_O(flag), .TIMER_BUSY_O(busy));

  rpt_tag_model i_tag (.clk_i(clk), .srst_i(srst), .eof_i(stb[1]),
    .resp_i(resp), .dly_i(4'h3), .rx_o(rx));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    chk(16'(rdata), 16'(exp));
  endtask : rd

  // bit 0 pulse request, bit 1 end of transmit, bit 2 flag clear
  task automatic pls(input int b);
    @(posedge clk);
    stb[b] <= 1'b1;
    @(posedge clk);
    stb <= 3'h0;
  endtask : pls

  // length of the next high stretch of the pulse (w=0) or busy (w=1)
  task automatic cnt(input logic w, output int c);
    int k;
    c = 0;
    k = 0;
    #1;
    while (((w ? busy : tx_mod) !== 1'b1) && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (((w ? busy : tx_mod) === 1'b1) && c < 5000) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask : cnt

  ////////////////////////////////////////////////////////////////////////
  task automatic t_proto;
    rd(PW_OFFSET, 8'h00);
    rd(SW_OFFSET, 8'h0E);
    rd(8'h10, 8'h00);
    wr(PW_OFFSET, 8'h05);
    wr(SW_OFFSET, 8'h21);
    rd(PW_OFFSET, 8'h05);
    rd(SW_OFFSET, 8'h21);
    @(posedge clk);
    pwr <= 1'b1;
    @(posedge clk);
    pwr    <= 1'b0;
    stb[1] <= 1'b1;
    @(posedge clk);
    stb <= 3'h0;
    // end of transmit right after a protocol write times the preset window
    cnt(1'b1, n);
    chk(16'(n), 16'(SW_RESET * SCY));
    chk(16'(flag), 16'h1);
    pls(2);
    rd(PW_OFFSET, 8'h00);
    rd(SW_OFFSET, 8'h0E);
  endtask : t_proto

  task automatic t_pulse;
    logic [11:0] pw [4];
    pw = '{PULSE_106_CYC, PULSE_212_CYC, PULSE_424_CYC, PULSE_848_CYC};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rate <= rpt_rate_t'(i);
      pls(0);
      cnt(1'b0, n);
      chk(16'(n), 16'(pw[i]));
    end
    wr(PW_OFFSET, 8'h01);
    pls(0);
    cnt(1'b0, n);
    chk(16'(n), 16'(PULSE_STEP_CYC));
    wr(PW_OFFSET, 8'hFF);
    pls(0);
    cnt(1'b0, n);
    chk(16'(n), 16'(PULSE_STEP_CYC * 255));
  endtask : t_pulse

  task automatic t_window;
    wr(SW_OFFSET, 8'h02);
    pls(1);
    cnt(1'b1, n);
    chk(16'(n), 16'(2 * SCY));
    chk(16'(irq), 16'h1);
    chk(16'(flag), 16'h1);
    pls(2);
    #1;
    chk(16'(irq), 16'h0);
    pls(1);
    repeat (3) @(posedge clk);
    pls(1);
    cnt(1'b1, n);
    chk(16'(n), 16'(2 * SCY));
    pls(2);
    // clear held high across the expiry edge: the set must win for one cycle
    pls(1);
    @(posedge clk);
    stb[2] <= 1'b1;
    repeat (7) @(posedge clk);
    #1;
    chk(16'(flag), 16'h1);
    @(posedge clk);
    stb <= 3'h0;
    @(posedge clk);
    resp <= 1'b1;
    pls(1);
    cnt(1'b1, n);
    // tag answers three cycles after the slot opens, window stops on the next edge
    chk(16'(n), 16'h0004);
    chk(16'(irq), 16'h0);
    resp <= 1'b0;
  endtask : t_window

  task automatic t_enable;
    wr(PW_OFFSET, 8'h07);
    wr(SW_OFFSET, 8'h03);
    rd(PW_OFFSET, 8'h07);
    rd(SW_OFFSET, 8'h03);
    @(posedge clk);
    en <= 1'b0;
    repeat (8) @(posedge clk);
    en <= 1'b1;
    repeat (8) @(posedge clk);
    rd(PW_OFFSET, 8'h00);
    rd(SW_OFFSET, 8'h0E);
  endtask : t_enable

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    t_proto();
    t_pulse();
    t_window();
    t_enable();
    give_verdict();
  end
endmodule : tb_rpt_timer_top
